// ---- irq_ctrl.sv ----
// Interrupt controller: 24 source flags, enables, priority, core request.
// Assumes request lines and register port are synchronous to ref_clk_i.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"

module irq_ctrl (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  // Register port
  input  wire irq_ctrl_pkg::reg_req_s   bus_i,
  output logic [`DATA_W-1:0]            rdata_o,
  // Peripheral requests
  input  wire irq_ctrl_pkg::src_s       src_i,
  // Core request
  output logic                          cpu_irq_o,
  output irq_ctrl_pkg::irq_pick_s       pick_o,
  // Controller own event interrupt
  output logic                          ctl_irq_o
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  // Reserved positions carry no source; every path that can set an
  // enable or a flag goes through this mask, so software reads zeros.
  localparam logic [`NUM_SRC-1:0]   VALID_MASK = `VALID_SRC_MASK;
  localparam logic [`NUM_LEVEL-1:0] LEVEL_MASK =
    VALID_MASK[`NUM_LEVEL-1:0];
  localparam logic [`NUM_EDGE-1:0]  EDGE_MASK  =
    VALID_MASK[`NUM_SRC-1:`NUM_LEVEL];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest index set in a 24-bit vector, with a found flag
  function automatic logic [`IDX_W:0] first_set(
    input logic [`NUM_SRC-1:0] vec
  );
    logic [`IDX_W:0] res;
    res = {1'b0, `RST_IDX};
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, i[`IDX_W-1:0]};
      end
    end
    return res;
  endfunction

  // Address match, a function so every write decode reads alike
  function automatic logic hit(
    input logic [`ADDR_W-1:0] a,
    input logic [`ADDR_W-1:0] b
  );
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [`NUM_SRC-1:0] enable_r;
  logic [`NUM_SRC-1:0] enable_nxt;
  logic [`NUM_SRC-1:0] prio_r;
  logic [`NUM_SRC-1:0] prio_nxt;
  logic [`DATA_W-1:0]  global_r;
  logic [`DATA_W-1:0]  global_nxt;
  logic [`DATA_W-1:0]  ev_enable_r;
  logic [`DATA_W-1:0]  ev_enable_nxt;

  logic                wr_en_lo;
  logic                wr_en_hi;
  logic                wr_en_edge;
  logic                wr_prio0;
  logic                wr_prio1;
  logic                wr_prio2;
  logic                wr_flag2;
  logic                wr_ev_clear;
  logic                wr_global;
  logic                wr_ev_enable;
  logic                mapped;

  assign wr_en_lo    = bus_i.wr && hit(bus_i.addr, `ADDR_EN_LO);
  assign wr_en_hi    = bus_i.wr && hit(bus_i.addr, `ADDR_EN_HI);
  assign wr_en_edge  = bus_i.wr && hit(bus_i.addr, `ADDR_EN_EDGE);
  assign wr_prio0    = bus_i.wr && hit(bus_i.addr, `ADDR_PRIO0);
  assign wr_prio1    = bus_i.wr && hit(bus_i.addr, `ADDR_PRIO1);
  assign wr_prio2    = bus_i.wr && hit(bus_i.addr, `ADDR_PRIO2);
  assign wr_flag2    = bus_i.wr && hit(bus_i.addr, `ADDR_FLAG2);
  assign wr_ev_clear = bus_i.wr && hit(bus_i.addr, `ADDR_EV_CLEAR);
  assign wr_global   = bus_i.wr && hit(bus_i.addr, `ADDR_GLOBAL);
  assign wr_ev_enable = bus_i.wr && hit(bus_i.addr, `ADDR_EV_ENABLE);

  always_comb begin
    mapped = 1'b0;
    unique case (bus_i.addr)
      `ADDR_EN_LO, `ADDR_EN_HI, `ADDR_EN_EDGE, `ADDR_GLOBAL,
      `ADDR_PRIO0, `ADDR_PRIO1, `ADDR_PRIO2,
      `ADDR_FLAG0, `ADDR_FLAG1, `ADDR_FLAG2,
      `ADDR_EV_STATUS, `ADDR_EV_CLEAR, `ADDR_EV_ENABLE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    enable_nxt    = enable_r;
    prio_nxt      = prio_r;
    global_nxt    = global_r;
    ev_enable_nxt = ev_enable_r;
    if (wr_en_lo) begin
      enable_nxt[7:0] = bus_i.wdata & VALID_MASK[7:0];
    end
    if (wr_en_hi) begin
      enable_nxt[15:8] = bus_i.wdata;
    end
    if (wr_en_edge) begin
      enable_nxt[23:16] = bus_i.wdata;
    end
    // reserved positions never hold an enable
    enable_nxt = enable_nxt & `VALID_SRC_MASK;
    // multi-address bit kept, bit 0 is master enable
    // Byte writes land at the next edge; no write ever waits
    if (wr_global) begin
      global_nxt = bus_i.wdata & `GLOBAL_MASK;
    end
    if (wr_prio0) begin
      prio_nxt[7:0] = bus_i.wdata;
    end
    if (wr_prio1) begin
      prio_nxt[15:8] = bus_i.wdata;
    end
    if (wr_prio2) begin
      prio_nxt[23:16] = bus_i.wdata;
    end
    if (wr_ev_enable) begin
      ev_enable_nxt = bus_i.wdata & `EV_MASK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_r    <= `RST_SRC;
      prio_r      <= `RST_SRC;
      global_r    <= `RST_BYTE;
      ev_enable_r <= `RST_BYTE;
    end else begin
      enable_r    <= enable_nxt;
      prio_r      <= prio_nxt;
      global_r    <= global_nxt;
      ev_enable_r <= ev_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Source flags
  // ----------------------------------------------------------------
  logic [`NUM_SRC-1:0]  flag_r;
  logic [`NUM_SRC-1:0]  flag_nxt;
  logic [`NUM_EDGE-1:0] edge_prev_r;
  logic [`NUM_EDGE-1:0] edge_rise;
  logic [`NUM_EDGE-1:0] edge_overrun;

  // Lines are taken as synchronous; a one-cycle glitch on a level
  // line shows in its flag for one cycle, no filtering is done here.
  // level flags mirror peripheral status only
  assign flag_nxt[`NUM_LEVEL-1:0] = src_i.level_req & LEVEL_MASK;

  genvar g;
  generate
    for (g = 0; g < `NUM_EDGE; g++) begin : g_edge
      localparam int P = `NUM_LEVEL + g;
      assign edge_rise[g] = src_i.edge_req[g] && !edge_prev_r[g]
                            && EDGE_MASK[g];
      // set wins over a same-cycle write-one clear
      assign flag_nxt[P] = edge_rise[g] ||
                           (flag_r[P] && !(wr_flag2 && bus_i.wdata[g]));
      assign edge_overrun[g] = edge_rise[g] && flag_r[P]
                               && !(wr_flag2 && bus_i.wdata[g]);
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_r      <= `RST_SRC;
      edge_prev_r <= `RST_BYTE;
    end else begin
      flag_r      <= flag_nxt;
      edge_prev_r <= src_i.edge_req;
    end
  end

  // ----------------------------------------------------------------
  // Request toward the core
  // ----------------------------------------------------------------
  logic                    cpu_irq_r;
  logic                    cpu_irq_nxt;
  irq_ctrl_pkg::irq_pick_s pick_r;
  irq_ctrl_pkg::irq_pick_s pick_nxt;
  logic [`NUM_SRC-1:0]     active;
  logic [`IDX_W:0]         hi_sel;
  logic [`IDX_W:0]         lo_sel;
  logic [`NUM_SRC-1:0]     hi_act;
  logic [`NUM_SRC-1:0]     lo_act;

  // Priority only orders the presented source; the core request is
  // the plain OR, so a low source is never held back by a high one.

  always_comb begin
    // flag AND enable, gated by master enable
    active      = flag_r & enable_r & {`NUM_SRC{global_r[`GLOBAL_EN_BIT]}};
    cpu_irq_nxt = |active;
    hi_act      = active & prio_r;
    lo_act      = active & ~prio_r;
    hi_sel      = first_set(hi_act);
    lo_sel      = first_set(lo_act);
    if (hi_sel[`IDX_W]) begin
      pick_nxt.valid = 1'b1;
      pick_nxt.high  = 1'b1;
      pick_nxt.index = hi_sel[`IDX_W-1:0];
    end else begin
      pick_nxt.valid = lo_sel[`IDX_W];
      pick_nxt.high  = 1'b0;
      pick_nxt.index = lo_sel[`IDX_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_irq_r <= 1'b0;
      pick_r    <= '0;
    end else begin
      cpu_irq_r <= cpu_irq_nxt;
      pick_r    <= pick_nxt;
    end
  end

  assign cpu_irq_o = cpu_irq_r;
  assign pick_o    = pick_r;

  // ----------------------------------------------------------------
  // Controller events
  // ----------------------------------------------------------------
  // Overrun: edge lost in an already set flag. Priority write is
  // flagged because changing priority is discouraged for software.
  logic [`DATA_W-1:0] ev_status_r;
  logic [`DATA_W-1:0] ev_status_nxt;
  logic [`DATA_W-1:0] ev_set;
  logic               ctl_irq_r;
  logic               ctl_irq_nxt;
  logic               overrun_any;
  logic               unmapped_acc;
  logic               prio_wr;

  // Any access outside the map is reported, reads included
  assign overrun_any  = |edge_overrun;
  assign unmapped_acc = (bus_i.wr || bus_i.rd) && !mapped;
  // flag software writing the priority bytes
  assign prio_wr      = wr_prio0 || wr_prio1 || wr_prio2;

  always_comb begin
    ev_set = `RST_BYTE;
    ev_set[`EV_OVERRUN_BIT]  = overrun_any;
    ev_set[`EV_UNMAPPED_BIT] = unmapped_acc;
    ev_set[`EV_PRIO_WR_BIT]  = prio_wr;
    ev_status_nxt = ev_status_r;
    if (wr_ev_clear) begin
      ev_status_nxt = ev_status_nxt & ~bus_i.wdata;
    end
    // Set wins over a same-cycle clear
    ev_status_nxt = (ev_status_nxt | ev_set) & `EV_MASK;
    ctl_irq_nxt   = |(ev_status_nxt & ev_enable_nxt);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_status_r <= `RST_BYTE;
      ctl_irq_r   <= 1'b0;
    end else begin
      ev_status_r <= ev_status_nxt;
      ctl_irq_r   <= ctl_irq_nxt;
    end
  end

  assign ctl_irq_o = ctl_irq_r;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Data only in the cycle after a read, zero otherwise, so an idle
  // bus never shows stale register contents.
  logic [`DATA_W-1:0] rdata_r;
  logic [`DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = `RST_BYTE;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `ADDR_EN_LO:     rdata_nxt = enable_r[7:0];
        `ADDR_EN_HI:     rdata_nxt = enable_r[15:8];
        `ADDR_EN_EDGE:   rdata_nxt = enable_r[23:16];
        `ADDR_GLOBAL:    rdata_nxt = global_r;
        `ADDR_PRIO0:     rdata_nxt = prio_r[7:0];
        `ADDR_PRIO1:     rdata_nxt = prio_r[15:8];
        `ADDR_PRIO2:     rdata_nxt = prio_r[23:16];
        // flag word in enable bit order
        `ADDR_FLAG0:     rdata_nxt = flag_r[7:0];
        `ADDR_FLAG1:     rdata_nxt = flag_r[15:8];
        `ADDR_FLAG2:     rdata_nxt = flag_r[23:16];
        `ADDR_EV_STATUS: rdata_nxt = ev_status_r;
        `ADDR_EV_ENABLE: rdata_nxt = ev_enable_r;
        default:         rdata_nxt = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= `RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule

// ---- irq_ctrl_asserts.sv ----
// Port checker for the interrupt controller.
// Assumes binding to irq_ctrl; enables shadowed from port writes.
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
module irq_ctrl_asserts (
  // Clock and reset
  input wire logic                    ref_clk_i,
  input wire logic                    reset_n_i,
  // Inputs
  input wire irq_ctrl_pkg::reg_req_s  bus_i,
  input wire irq_ctrl_pkg::src_s      src_i,
  // Outputs
  input wire logic [`DATA_W-1:0]      rdata_o,
  input wire logic                    cpu_irq_o,
  input wire irq_ctrl_pkg::irq_pick_s pick_o
);
  localparam logic [`NUM_SRC-1:0] VM = `VALID_SRC_MASK;
  logic [`NUM_SRC-1:0] en_r;
  logic                g_r;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------
  // Shadow of enables
  // ------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_r <= `RST_SRC;
      g_r  <= 1'b0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `ADDR_EN_LO) en_r[7:0] <= bus_i.wdata;
      if (bus_i.addr == `ADDR_EN_HI) en_r[15:8] <= bus_i.wdata;
      if (bus_i.addr == `ADDR_EN_EDGE) en_r[23:16] <= bus_i.wdata;
      if (bus_i.addr == `ADDR_GLOBAL) g_r <= bus_i.wdata[0];
    end
  end
  property p_gate;
    !$past(g_r) |-> !cpu_irq_o;
  endproperty
  a_gate: assert property (p_gate) else $error("request without global");
  property p_level;
    (|(src_i.level_req & en_r[15:0] & VM[15:0])) && g_r && !bus_i.wr
      |-> ##2 cpu_irq_o;
  endproperty
  a_level: assert property (p_level) else $error("level lost");
  property p_edge;
    (|(src_i.edge_req & ~$past(src_i.edge_req) & en_r[23:16] & VM[23:16]))
      && g_r && !bus_i.wr |-> ##2 cpu_irq_o;
  endproperty
  a_edge: assert property (p_edge) else $error("edge lost");
  property p_high;
    pick_o.high |-> pick_o.valid;
  endproperty
  a_high: assert property (p_high) else $error("high without valid");
  property p_resv;
    pick_o.valid |-> VM[pick_o.index];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved source");
  property p_idle;
    !$past(bus_i.rd) |-> rdata_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data stands");
  property p_pick;
    cpu_irq_o |-> pick_o.valid;
  endproperty
  a_pick: assert property (p_pick) else $error("no source picked");
  property p_rden;
    bus_i.rd && bus_i.addr == `ADDR_EN_EDGE
      |=> rdata_o == ($past(en_r[23:16]) & VM[23:16]);
  endproperty
  a_rden: assert property (p_rden) else $error("edge enable read");
endmodule
bind irq_ctrl irq_ctrl_asserts u_chk (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .bus_i(bus_i), .src_i(src_i),
  .rdata_o(rdata_o), .cpu_irq_o(cpu_irq_o), .pick_o(pick_o));

// ---- irq_ctrl_cfg.svh ----
// Register map, field masks, reset values of the interrupt controller.
// Assumes byte-wide registers reached at their printed byte addresses.
//
// Contract
// - Low level enable byte gates host-cmd, UART, FIFO, DMA, counters; bit 3 reserved.
// - High level enable byte gates key engine, PWM, radio; bits 4..0 reserved.
// - Edge enable byte gates routed pins, tick, wakeup, GPIO; bits 7,1,0 reserved.
// - No request reaches the processor unless global control bit 0 is one; here it gates cpu_irq_o and pick_o only, ctl_irq_o ignores it.
// - Global control bit 1 is stored but never affects delivery.
// - One priority bit per source over three bytes; one means high.
// - Simultaneous enabled requests present high priority ahead of low.
// - A request sets the source flag in the read-only source bytes.
// - Source bytes form one 24-bit word matching enable bit positions.
// - Writing one to an edge flag in the top byte clears it.
// - Level flags follow the peripheral status; source-byte writes never clear them.
// - Twenty-four source positions: sixteen level type, eight edge type; nine reserved.
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define ADDR_W          12
`define DATA_W          8
`define NUM_SRC         24
`define NUM_LEVEL       16
`define NUM_EDGE        8
`define IDX_W           5

`define ADDR_EN_LO      12'h640
`define ADDR_EN_HI      12'h641
`define ADDR_EN_EDGE    12'h642
`define ADDR_GLOBAL     12'h643
`define ADDR_PRIO0      12'h644
`define ADDR_PRIO1      12'h645
`define ADDR_PRIO2      12'h646
`define ADDR_FLAG0      12'h648
`define ADDR_FLAG1      12'h649
`define ADDR_FLAG2      12'h64A
`define ADDR_EV_STATUS  12'h64C
`define ADDR_EV_CLEAR   12'h64D
`define ADDR_EV_ENABLE  12'h64E

`define VALID_SRC_MASK  24'h7C_E0_F7
`define GLOBAL_MASK     8'h03
`define GLOBAL_EN_BIT   0
`define EV_MASK         8'h07
`define EV_OVERRUN_BIT  0
`define EV_UNMAPPED_BIT 1
`define EV_PRIO_WR_BIT  2

`define RST_BYTE        8'h00
`define RST_SRC         24'h00_00_00
`define RST_IDX         5'h00

`endif

// ---- irq_ctrl_pkg.sv ----
// Types shared by the interrupt controller and its surroundings.
// Assumes the constants header is included by every user.
`include "irq_ctrl_cfg.svh"

package irq_ctrl_pkg;

  // One register port access
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } reg_req_s;

  // Peripheral request lines, edge group on top
  typedef struct packed {
    logic [`NUM_EDGE-1:0]  edge_req;
    logic [`NUM_LEVEL-1:0] level_req;
  } src_s;

  // Presented request toward the core
  typedef struct packed {
    logic              valid;
    logic              high;
    logic [`IDX_W-1:0] index;
  } irq_pick_s;

endpackage

// ---- periph_model.sv ----
// Peripheral side: level status bits and edge request pulses.
// Assumes bench strobes are one cycle long.
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
module periph_model (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  // Bench control
  input  wire logic [`NUM_LEVEL-1:0] raise_i,
  input  wire logic [`NUM_LEVEL-1:0] status_clr_i,
  input  wire logic [`NUM_EDGE-1:0]  pulse_i,
  // Request lines
  output irq_ctrl_pkg::src_s         src_o
);
  irq_ctrl_pkg::src_s src_r, src_nxt;
  always_comb begin
    src_nxt.level_req = (src_r.level_req | raise_i) & ~status_clr_i;
    src_nxt.edge_req = pulse_i;
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) src_r <= `RST_SRC;
    else src_r <= src_nxt;
  end
  assign src_o = src_r;
endmodule

// ---- tb_irq_mask_priority_flags.sv ----
// Self-checking bench for the interrupt controller.
// Assumes periph_model drives the request lines.
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
module tb_irq_mask_priority_flags;
  localparam logic [23:0] VM = `VALID_SRC_MASK;
  logic ref_clk_i, reset_n_i, cpu_irq, ctl_irq;
  irq_ctrl_pkg::reg_req_s  bus;
  irq_ctrl_pkg::src_s      src;
  irq_ctrl_pkg::irq_pick_s pick;
  logic [7:0]  rdata, d, pulse;
  logic [15:0] raise, sclr;
  logic [31:0] lf, mk;
  int n_fail, n_tests, cyc, m_lvl, m_edge, m_en, m_g, m_pr;
  irq_ctrl dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
    .rdata_o(rdata), .src_i(src), .cpu_irq_o(cpu_irq), .pick_o(pick),
    .ctl_irq_o(ctl_irq));
  periph_model u_per (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .raise_i(raise), .status_clr_i(sclr), .pulse_i(pulse), .src_o(src));
  // ------------------------------
  // Tasks
  // ------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic final_report();
    $display("fails %0d tests %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk_i) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk_i) bus.wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i) bus.rd <= 1'b0;
    #1 cmp_v(rdata, e);
  endtask
  task automatic poke(input logic [15:0] r, c, input logic [7:0] p);
    @(posedge ref_clk_i) {raise, sclr, pulse} <= {r, c, p};
    @(posedge ref_clk_i) {raise, sclr, pulse} <= 40'h0;
    m_lvl = (m_lvl | r) & ~c;
    m_edge |= p;
  endtask
  task automatic cmp_pick();
    int act, s, ix;
    repeat (3) @(posedge ref_clk_i);
    #1 act = (m_lvl | (m_edge << 16)) & VM & m_en;
    if (!m_g[0]) act = 0;
    s = ((act & m_pr) != 0) ? (act & m_pr) : act;
    ix = 0;
    while (ix < 24 && !s[ix]) ix++;
    n_tests++;
    if (cpu_irq !== (act != 0) || (act != 0 &&
        pick !== {1'b1, (act & m_pr) != 0, ix[4:0]})) begin
      n_fail++;
      $display("[FAIL] %0t core request %b pick %h", $time, cpu_irq, pick);
    end
  endtask
  // ------------------------------
  // Clock, timeout, sequence
  // ------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {reset_n_i, raise, sclr, pulse} = 41'h0;
    bus = '0;
    {m_lvl, m_edge, m_pr} = 0;
    lf = 32'h0001_6298;
    mk = 32'h037C_E0F7;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int a = 12'h640; a <= 12'h64A; a++) chk_rd(12'(a), 8'h00);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wr(12'(12'h640 + i), lf[7:0]);
      chk_rd(12'(12'h640 + i), lf[7:0] & mk[8*i +: 8]);
    end
    // Enables before global, as software must
    for (int i = 0; i < 3; i++) wr(12'(12'h640 + i), 8'hFF);
    m_en = VM;
    wr(`ADDR_GLOBAL, 8'h01);
    m_g = 1;
    // Unmapped read above raised event bit 1
    wr(`ADDR_EV_ENABLE, 8'h02);
    chk_rd(`ADDR_EV_STATUS, 8'h02);
    cmp_v({7'h00, ctl_irq}, 8'h01);
    wr(`ADDR_EV_CLEAR, 8'h07);
    chk_rd(`ADDR_EV_STATUS, 8'h00);
    cmp_v({7'h00, ctl_irq}, 8'h00);
    poke(16'h0001, 16'h0000, 8'h00);
    cmp_pick();
    chk_rd(`ADDR_FLAG0, 8'h01);
    wr(`ADDR_FLAG0, 8'hFF);
    chk_rd(`ADDR_FLAG0, 8'h01);
    poke(16'h0000, 16'h0001, 8'h00);
    cmp_pick();
    chk_rd(`ADDR_FLAG0, 8'h00);
    poke(16'h0000, 16'h0000, 8'h04);
    cmp_pick();
    chk_rd(`ADDR_FLAG2, 8'h04);
    wr(`ADDR_FLAG2, 8'h04);
    m_edge = 0;
    chk_rd(`ADDR_FLAG2, 8'h00);
    poke(16'h0040, 16'h0000, 8'h10);
    cmp_pick();
    wr(`ADDR_PRIO2, 8'h10);
    m_pr = 32'h0010_0000;
    chk_rd(`ADDR_EV_STATUS, 8'h04);
    cmp_pick();
    wr(`ADDR_GLOBAL, 8'h02);
    m_g = 2;
    cmp_pick();
    chk_rd(`ADDR_GLOBAL, 8'h02);
    wr(`ADDR_GLOBAL, 8'h03);
    m_g = 3;
    cmp_pick();
    // Second rise on a set edge flag: flag holds, overrun reported
    poke(16'h0000, 16'h0000, 8'h10);
    chk_rd(`ADDR_EV_STATUS, 8'h05);
    chk_rd(`ADDR_FLAG2, 8'h10);
    cmp_pick();
    final_report();
  end
endmodule
